// [rtl/scu_pkg.sv]
// Purpose: Shared constants for one serial channel (async, clock synchronous, two-wire)
// Assumes: Single sys_clk domain, all rates derived as enable pulses
// Notes: Frame format fixed at eight data bits, LSB first, one stop bit in async mode, none in sync mode
`default_nettype none

package scu_pkg;

	// ----------------------------------------
	// Clock source selection codes
	// ----------------------------------------
	localparam logic [1:0] SCU_CLKSEL_DIV1 = 2'h0;
	localparam logic [1:0] SCU_CLKSEL_DIV2 = 2'h1;
	localparam logic [1:0] SCU_CLKSEL_DIV8 = 2'h2;
	localparam logic [1:0] SCU_CLKSEL_DIV32 = 2'h3;

	// ----------------------------------------
	// Prescaler tap positions
	// ----------------------------------------
	localparam int SCU_PRESCALE_BITS = 5;
	localparam logic [4:0] SCU_TAP_DIV2 = 5'h01;
	localparam logic [4:0] SCU_TAP_DIV8 = 5'h07;
	localparam logic [4:0] SCU_TAP_DIV32 = 5'h1F;

	// ----------------------------------------
	// Bit timing, in baud generator ticks
	// ----------------------------------------
	localparam logic [4:0] SCU_ASYNC_TICKS = 5'h10;
	localparam logic [4:0] SCU_ASYNC_MID = 5'h07;
	localparam logic [4:0] SCU_SYNC_HALF = 5'h04;
	localparam logic [4:0] SCU_SYNC_TICKS = 5'h08;
	localparam logic [1:0] SCU_START_WAIT_OVF = 2'h2;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int SCU_DATA_BITS = 8;
	localparam logic [3:0] SCU_ASYNC_FRAME_BITS = 4'hA;
	localparam logic [3:0] SCU_SYNC_FRAME_BITS = 4'h8;
	localparam logic [3:0] SCU_SYNC_OVR_BIT = 4'h7;
	localparam logic [3:0] SCU_ASYNC_OVR_BIT = 4'h8;

	// ----------------------------------------
	// Line levels and FIFO depth
	// ----------------------------------------
	localparam logic SCU_RTS_RESET = 1'b0;
	localparam logic SCU_LINE_IDLE = 1'b1;
	localparam int SCU_FIFO_DEPTH = 16;

endpackage : scu_pkg

`default_nettype wire

// [rtl/scu_fifo.sv]
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH of at least two
// Notes: Ready and valid are registered from the next occupancy
`default_nettype none

module scu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = scu_pkg::SCU_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign count_next = count_reg + CW'(push) - CW'(pop);
	assign out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
			count_reg <= count_next;
			in_ready <= (count_next != CW'(DEPTH));
			out_valid <= (count_next != '0);
		end
	end

endmodule : scu_fifo

`default_nettype wire

// [rtl/scu_brg.sv]
// Purpose: Clock source prescaler and reloading baud rate generator
// Assumes: Divisor is held stable while the channel runs
// Notes: One tick per overflow, divisor N gives a period of N+1 source pulses
`default_nettype none

module scu_brg #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [1:0] clk_select,
	input wire logic [DIV_WIDTH-1:0] divisor,
	output logic tick
);

	logic [scu_pkg::SCU_PRESCALE_BITS-1:0] pre_reg;
	logic [DIV_WIDTH-1:0] count_reg;
	logic src_en;

	// ----------------------------------------
	// Four prescaled sources
	// ----------------------------------------
	always_comb
	begin
		unique case (clk_select)
			scu_pkg::SCU_CLKSEL_DIV1: src_en = 1'b1;
			scu_pkg::SCU_CLKSEL_DIV2: src_en = (pre_reg[0] == scu_pkg::SCU_TAP_DIV2[0]);
			scu_pkg::SCU_CLKSEL_DIV8: src_en = (pre_reg[2:0] == scu_pkg::SCU_TAP_DIV8[2:0]);
			scu_pkg::SCU_CLKSEL_DIV32: src_en = (pre_reg == scu_pkg::SCU_TAP_DIV32);
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			pre_reg <= '0;
		else
			pre_reg <= pre_reg + scu_pkg::SCU_PRESCALE_BITS'(1);
	end

	// ----------------------------------------
	// Reloading down counter
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			count_reg <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (src_en)
			begin
				if (count_reg == '0)
				begin
					count_reg <= divisor;
					tick <= 1'b1;
				end
				else
					count_reg <= count_reg - DIV_WIDTH'(1);
			end
		end
	end

endmodule : scu_brg

`default_nettype wire

// [rtl/scu_channel.sv]
// Purpose: One serial channel: async, clock synchronous master and two-wire bus
// Assumes: Inputs synchronous to sys_clk; identical instances serve every channel
// Notes: Transmit data passes a FIFO; receive side is a single buffer register
`default_nettype none

module scu_channel #(
	parameter int DIV_WIDTH = 8,
	parameter int FIFO_DEPTH = scu_pkg::SCU_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic cfg_sync_mode,
	input wire logic cfg_twowire_mode,
	input wire logic [1:0] cfg_clk_select,
	input wire logic [DIV_WIDTH-1:0] cfg_divisor,
	input wire logic cfg_handshake_split,
	input wire logic cfg_cts_enable,
	input wire logic cfg_rts_enable,
	input wire logic [2:0] cfg_sda_delay,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic tx_busy,
	input wire logic rx_read,
	output logic [7:0] rx_data,
	output logic rx_full,
	output logic overrun_error,
	output logic framing_error,
	input wire logic err_clear,
	input wire logic gen_start,
	input wire logic gen_stop,
	output logic cond_busy,
	output logic txd,
	input wire logic rxd,
	output logic sclk,
	input wire logic cts_rts_in,
	output logic cts_rts_out,
	output logic cts_rts_oe,
	output logic rts_n_sep,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);

	typedef enum logic [2:0] {
		SCU_TX_IDLE = 3'h1,
		SCU_TX_WAIT = 3'h2,
		SCU_TX_SHIFT = 3'h4
	} scu_tx_state_t;

	typedef enum logic [3:0] {
		SCU_RX_IDLE = 4'h1,
		SCU_RX_START = 4'h2,
		SCU_RX_DATA = 4'h4,
		SCU_RX_STOP = 4'h8
	} scu_rx_state_t;

	typedef enum logic [5:0] {
		SCU_BC_IDLE = 6'h01,
		SCU_BC_START_A = 6'h02,
		SCU_BC_START_B = 6'h04,
		SCU_BC_STOP_A = 6'h08,
		SCU_BC_STOP_B = 6'h10,
		SCU_BC_STOP_C = 6'h20
	} scu_bc_state_t;

	scu_tx_state_t tx_state_reg;
	scu_rx_state_t rx_state_reg;
	scu_bc_state_t bc_state_reg;
	logic tick;
	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;
	logic [1:0] ovf_cnt_reg;
	logic [9:0] tx_shift_reg;
	logic [4:0] tx_phase_reg;
	logic [3:0] tx_bits_reg;
	logic [4:0] rx_phase_reg;
	logic [3:0] rx_bits_reg;
	logic [7:0] rx_shift_reg;
	logic began_full_reg;
	logic sda_bit_reg;
	logic [2:0] sda_cnt_reg;
	logic bit_edge_reg;
	logic rx_load;
	logic ovr_set;
	logic frame_set;
	logic cts_ok;
	logic stall;
	logic rx_line;
	logic sync_rise;
	logic [4:0] bit_len;
	logic [3:0] frame_bits;

	scu_brg #(
		.DIV_WIDTH(DIV_WIDTH)
	) u_brg (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_select(cfg_clk_select),
		.divisor(cfg_divisor),
		.tick(tick)
	);

	scu_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_valid(tx_valid),
		.in_data(tx_data),
		.in_ready(tx_ready),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// ----------------------------------------
	// Handshake pin routing
	// ----------------------------------------
	// Shared pin is CTS input unless combined mode gives it to RTS
	assign cts_ok = !cfg_cts_enable || (!cfg_handshake_split && cfg_rts_enable) || !cts_rts_in;
	assign stall = cfg_twowire_mode && sclk && !scl_in;
	assign rx_line = cfg_twowire_mode ? sda_in : rxd;
	assign bit_len = cfg_sync_mode ? scu_pkg::SCU_SYNC_TICKS : scu_pkg::SCU_ASYNC_TICKS;
	assign frame_bits = cfg_sync_mode ? scu_pkg::SCU_SYNC_FRAME_BITS : scu_pkg::SCU_ASYNC_FRAME_BITS;
	assign fifo_pop = (tx_state_reg == SCU_TX_WAIT) && tick
		&& (ovf_cnt_reg == scu_pkg::SCU_START_WAIT_OVF - 2'h1);
	assign sync_rise = cfg_sync_mode && (tx_state_reg == SCU_TX_SHIFT) && tick && !stall
		&& (tx_phase_reg == scu_pkg::SCU_SYNC_HALF - 5'h01);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			tx_state_reg <= SCU_TX_IDLE;
			ovf_cnt_reg <= 2'h0;
			tx_shift_reg <= '1;
			tx_phase_reg <= 5'h00;
			tx_bits_reg <= 4'h0;
			bit_edge_reg <= 1'b0;
		end
		else
		begin
			bit_edge_reg <= 1'b0;
			unique case (tx_state_reg)
				SCU_TX_IDLE:
				begin
					ovf_cnt_reg <= 2'h0;
					if (fifo_valid && cts_ok && (bc_state_reg == SCU_BC_IDLE))
						tx_state_reg <= SCU_TX_WAIT;
				end
				SCU_TX_WAIT:
				begin
					if (tick)
						ovf_cnt_reg <= ovf_cnt_reg + 2'h1;
					if (fifo_pop)
					begin
						tx_state_reg <= SCU_TX_SHIFT;
						tx_shift_reg <= cfg_sync_mode ? {2'h3, fifo_data} : {1'b1, fifo_data, 1'b0};
						tx_phase_reg <= 5'h00;
						tx_bits_reg <= 4'h0;
						bit_edge_reg <= 1'b1;
					end
				end
				SCU_TX_SHIFT:
				begin
					if (tick && !stall)
					begin
						if (tx_phase_reg == bit_len - 5'h01)
						begin
							tx_phase_reg <= 5'h00;
							tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
							tx_bits_reg <= tx_bits_reg + 4'h1;
							bit_edge_reg <= 1'b1;
							if (tx_bits_reg == frame_bits - 4'h1)
								tx_state_reg <= SCU_TX_IDLE;
						end
						else
							tx_phase_reg <= tx_phase_reg + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			txd <= scu_pkg::SCU_LINE_IDLE;
			sclk <= scu_pkg::SCU_LINE_IDLE;
			tx_busy <= 1'b0;
		end
		else
		begin
			txd <= (tx_state_reg == SCU_TX_SHIFT) ? tx_shift_reg[0] : scu_pkg::SCU_LINE_IDLE;
			sclk <= !(cfg_sync_mode && (tx_state_reg == SCU_TX_SHIFT)
				&& (tx_phase_reg < scu_pkg::SCU_SYNC_HALF));
			tx_busy <= (tx_state_reg != SCU_TX_IDLE) || fifo_valid;
		end
	end

	// ----------------------------------------
	// Receiver, both modes
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			rx_state_reg <= SCU_RX_IDLE;
			rx_phase_reg <= 5'h00;
			rx_bits_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			began_full_reg <= 1'b0;
			rx_load <= 1'b0;
			ovr_set <= 1'b0;
			frame_set <= 1'b0;
		end
		else
		begin
			rx_load <= 1'b0;
			ovr_set <= 1'b0;
			frame_set <= 1'b0;
			if (cfg_sync_mode)
			begin
				rx_state_reg <= SCU_RX_IDLE;
				if (sync_rise)
				begin
					rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
					rx_bits_reg <= (rx_bits_reg == scu_pkg::SCU_SYNC_FRAME_BITS - 4'h1) ? 4'h0
						: rx_bits_reg + 4'h1;
					if (rx_bits_reg == 4'h0)
						began_full_reg <= rx_full;
					if ((rx_bits_reg == scu_pkg::SCU_SYNC_OVR_BIT - 4'h1)
						&& began_full_reg && rx_full)
						ovr_set <= 1'b1;
					if (rx_bits_reg == scu_pkg::SCU_SYNC_FRAME_BITS - 4'h1)
						rx_load <= 1'b1;
				end
			end
			else if (tick)
			begin
				unique case (rx_state_reg)
					SCU_RX_IDLE:
					begin
						rx_phase_reg <= 5'h00;
						rx_bits_reg <= 4'h0;
						if (!rx_line)
							rx_state_reg <= SCU_RX_START;
					end
					SCU_RX_START:
					begin
						rx_phase_reg <= rx_phase_reg + 5'h01;
						if (rx_phase_reg == scu_pkg::SCU_ASYNC_MID)
						begin
							rx_phase_reg <= 5'h00;
							rx_state_reg <= rx_line ? SCU_RX_IDLE : SCU_RX_DATA;
							began_full_reg <= rx_full;
						end
					end
					SCU_RX_DATA:
					begin
						rx_phase_reg <= rx_phase_reg + 5'h01;
						if (rx_phase_reg == scu_pkg::SCU_ASYNC_TICKS - 5'h01)
						begin
							rx_phase_reg <= 5'h00;
							rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
							rx_bits_reg <= rx_bits_reg + 4'h1;
							if (rx_bits_reg == scu_pkg::SCU_ASYNC_OVR_BIT - 4'h1)
							begin
								rx_state_reg <= SCU_RX_STOP;
								if (began_full_reg && rx_full)
									ovr_set <= 1'b1;
							end
						end
					end
					SCU_RX_STOP:
					begin
						rx_phase_reg <= rx_phase_reg + 5'h01;
						if (rx_phase_reg == scu_pkg::SCU_ASYNC_TICKS - 5'h01)
						begin
							rx_state_reg <= SCU_RX_IDLE;
							rx_load <= rx_line;
							frame_set <= !rx_line;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Receive buffer, flags and RTS
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			rx_data <= 8'h00;
			rx_full <= 1'b0;
			overrun_error <= 1'b0;
			framing_error <= 1'b0;
			rts_n_sep <= scu_pkg::SCU_LINE_IDLE;
			cts_rts_out <= scu_pkg::SCU_LINE_IDLE;
			cts_rts_oe <= 1'b0;
		end
		else
		begin
			// Unread buffer keeps its old word on overrun
			if (rx_load && (!rx_full || rx_read))
				rx_data <= rx_shift_reg;
			if (rx_load)
				rx_full <= 1'b1;
			else if (rx_read)
				rx_full <= 1'b0;
			if (ovr_set)
				overrun_error <= 1'b1;
			else if (err_clear)
				overrun_error <= 1'b0;
			if (frame_set)
				framing_error <= 1'b1;
			else if (err_clear)
				framing_error <= 1'b0;
			if (!cfg_rts_enable)
				cts_rts_out <= scu_pkg::SCU_LINE_IDLE;
			else if (rx_load)
				cts_rts_out <= 1'b1;
			else if (rx_read)
				cts_rts_out <= scu_pkg::SCU_RTS_RESET;
			rts_n_sep <= cfg_handshake_split ? cts_rts_out : scu_pkg::SCU_LINE_IDLE;
			cts_rts_oe <= cfg_rts_enable && !cfg_handshake_split;
		end
	end

	// ----------------------------------------
	// Two-wire conditions and data delay
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			bc_state_reg <= SCU_BC_IDLE;
		else if (!cfg_twowire_mode)
			bc_state_reg <= SCU_BC_IDLE;
		else
		begin
			unique case (bc_state_reg)
				SCU_BC_IDLE:
				begin
					if (gen_start && (tx_state_reg == SCU_TX_IDLE))
						bc_state_reg <= SCU_BC_START_A;
					else if (gen_stop && (tx_state_reg == SCU_TX_IDLE))
						bc_state_reg <= SCU_BC_STOP_A;
				end
				SCU_BC_START_A: if (tick) bc_state_reg <= SCU_BC_START_B;
				SCU_BC_START_B: if (tick) bc_state_reg <= SCU_BC_IDLE;
				SCU_BC_STOP_A: if (tick) bc_state_reg <= SCU_BC_STOP_B;
				SCU_BC_STOP_B: if (tick) bc_state_reg <= SCU_BC_STOP_C;
				SCU_BC_STOP_C: if (tick) bc_state_reg <= SCU_BC_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			sda_cnt_reg <= 3'h0;
			sda_bit_reg <= scu_pkg::SCU_LINE_IDLE;
		end
		else if (bit_edge_reg)
			sda_cnt_reg <= cfg_sda_delay;
		else if (tick)
		begin
			if (sda_cnt_reg == 3'h0)
				sda_bit_reg <= (tx_state_reg == SCU_TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
			else
				sda_cnt_reg <= sda_cnt_reg - 3'h1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			cond_busy <= 1'b0;
		end
		else
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			cond_busy <= (bc_state_reg != SCU_BC_IDLE);
			unique case (bc_state_reg)
				SCU_BC_START_A:
				begin
					scl_oe <= 1'b0;
					sda_oe <= 1'b1;
				end
				SCU_BC_START_B, SCU_BC_STOP_A:
				begin
					scl_oe <= 1'b1;
					sda_oe <= 1'b1;
				end
				SCU_BC_STOP_B:
				begin
					scl_oe <= 1'b0;
					sda_oe <= 1'b1;
				end
				SCU_BC_STOP_C:
				begin
					scl_oe <= 1'b0;
					sda_oe <= 1'b0;
				end
				SCU_BC_IDLE:
				begin
					// Clock held low after a start until the first byte shifts
					scl_oe <= cfg_twowire_mode && (!sclk || scl_oe && (tx_state_reg != SCU_TX_SHIFT));
					sda_oe <= cfg_twowire_mode && !sda_bit_reg;
				end
			endcase
		end
	end

endmodule : scu_channel

`default_nettype wire

// [bench/scu_checker.sv]
// Purpose: Port checks for one serial channel
// Assumes: One clock domain, reset synchronous
// Notes: Bound to scu_channel from tb_top
`default_nettype none

module scu_checker #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic cfg_sync_mode,
	input wire logic cfg_handshake_split,
	input wire logic cfg_rts_enable,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_busy,
	input wire logic rx_read,
	input wire logic [7:0] rx_data,
	input wire logic rx_full,
	input wire logic overrun_error,
	input wire logic err_clear,
	input wire logic txd,
	input wire logic sclk,
	input wire logic cts_rts_out,
	input wire logic cts_rts_oe,
	input wire logic rts_n_sep
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_read_full;
		rx_read && rx_full && cfg_rts_enable;
	endsequence
	sequence s_ready_again;
		##[1:2] (rx_full || (cfg_handshake_split ? !rts_n_sep : !cts_rts_out));
	endsequence
	a_rts_on_read: assert property (s_read_full |-> s_ready_again)
		else $error("request line not lowered after buffer read");
	a_rts_while_full: assert property (rx_full && $past(rx_full) && cfg_rts_enable
		|-> (cfg_handshake_split ? rts_n_sep : cts_rts_out))
		else $error("request line low while buffer full");
	a_ovr_needs_full: assert property ($rose(overrun_error) |-> rx_full && $past(rx_full))
		else $error("overrun without unread buffer");
	a_err_sticky: assert property (overrun_error && !err_clear |=> overrun_error)
		else $error("overrun flag dropped");
	a_rx_data_hold: assert property (rx_full && !rx_read |=> rx_full && $stable(rx_data))
		else $error("unread buffer changed");
	a_start_has_data: assert property ($fell(txd) |-> $past(tx_busy))
		else $error("line left idle with nothing to send");
	a_tx_wait_two: assert property (tx_valid && tx_ready && !tx_busy |=> txd[*3])
		else $error("send began before second overflow");
	a_split_no_drive: assert property (cfg_handshake_split && $past(cfg_handshake_split)
		|-> !cts_rts_oe)
		else $error("shared pin driven in split mode");
	a_sclk_async_idle: assert property (!cfg_sync_mode && !$past(cfg_sync_mode) |-> sclk)
		else $error("serial clock moved in async mode");
endmodule : scu_checker

`default_nettype wire

// [bench/scu_peer.sv]
// Purpose: Remote serial peer on the receive line
// Assumes: Bit period given in sys_clk cycles
// Notes: Sync mode presents a fixed byte, next bit on falling sclk
`default_nettype none

module scu_peer (
	input wire logic sys_clk,
	input wire logic sync_en,
	input wire logic sclk,
	output logic rxd,
	output logic cts_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Line model
	// ----------------------------------------
	logic line = 1'h1;
	logic sclk_d = 1'h1;
	logic [2:0] rises = 3'h0;
	logic [2:0] idx = 3'h0;
	logic [7:0] sync_byte = 8'h96;
	initial cts_n = 1'h0;
	assign rxd = sync_en ? sync_byte[idx] : line;
	always @(posedge sys_clk)
	begin
		sclk_d <= sclk;
		if (sync_en && sclk && !sclk_d)
			rises <= rises + 3'h1;
		if (sync_en && !sclk && sclk_d)
			idx <= rises;
	end
	task automatic send(input logic [7:0] b, input int bit_cyc);
		logic [9:0] fr;
		fr = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++)
		begin
			line <= fr[i];
			repeat (bit_cyc) @(posedge sys_clk);
		end
	endtask : send
	task automatic set_cts(input logic v);
		cts_n <= v;
	endtask : set_cts
endmodule : scu_peer

`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for one serial channel
// Assumes: Peer model on the line, tick period P = prescale * (divisor + 1)
// Notes: Async bit is 16 ticks, sync bit 8 ticks
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic sys_clk = 1'h0, reset_n = 1'h0, cfg_sync_mode = 1'h0, cfg_twowire_mode = 1'h0;
	logic cfg_handshake_split = 1'h0, cfg_cts_enable = 1'h0, cfg_rts_enable = 1'h1;
	logic [1:0] cfg_clk_select = 2'h0;
	logic [7:0] cfg_divisor = 8'h00, tx_data = 8'h00, rx_data;
	logic [2:0] cfg_sda_delay = 3'h2;
	logic tx_valid = 1'h0, rx_read = 1'h0, err_clear = 1'h0, gen_start = 1'h0, gen_stop = 1'h0;
	logic tx_ready, tx_busy, rx_full, overrun_error, framing_error, cond_busy, txd, rxd, sclk;
	logic cts_rts_in, cts_rts_out, cts_rts_oe, rts_n_sep, peer_cts_n;
	logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
	int fails = 0, total_checks = 0;
	always #2 sys_clk = ~sys_clk;
	assign cts_rts_in = cts_rts_oe ? cts_rts_out : peer_cts_n;
	assign scl_in = !scl_oe;
	assign sda_in = !sda_oe;
	scu_channel u_dut (.*);
	scu_peer u_peer (.sys_clk(sys_clk), .sync_en(cfg_sync_mode), .sclk(sclk), .rxd(rxd),
		.cts_n(peer_cts_n));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic pulse_read_clear();
		@(posedge sys_clk);
		rx_read <= 1'h1;
		err_clear <= 1'h1;
		@(posedge sys_clk);
		rx_read <= 1'h0;
		err_clear <= 1'h0;
		step(2);
	endtask : pulse_read_clear
	task automatic put(input logic [7:0] b);
		@(posedge sys_clk);
		tx_data <= b;
		tx_valid <= 1'h1;
		#1;
		for (int n = 0; n < 50 && tx_ready !== 1'h1; n++) step(1);
		@(posedge sys_clk);
		tx_valid <= 1'h0;
		#1;
	endtask : put
	task automatic rises(input int k);
		logic prev;
		prev = sclk;
		for (int n = 0; n < 2000 && k > 0; n++)
		begin
			step(1);
			if (sclk === 1'h1 && prev === 1'h0)
				k--;
			prev = sclk;
		end
	endtask : rises
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_tx(input logic [1:0] sel, input logic [7:0] dv, input int p);
		int n;
		logic [8:0] got;
		@(posedge sys_clk);
		cfg_clk_select <= sel;
		cfg_divisor <= dv;
		repeat (80) @(posedge sys_clk);
		put(8'hA5);
		for (n = 0; n < 4 * p + 9 && txd === 1'h1; n++) step(1);
		check("start delay", n >= p + 2 && n <= 2 * p + 4, 1'h1);
		for (n = 0; n < 40 * p && txd === 1'h0; n++) step(1);
		check("start width", n, 16 * p);
		step(8 * p);
		for (int i = 0; i < 9; i++)
		begin
			got[i] = txd;
			step(16 * p);
		end
		check("tx frame", got, 9'h1A5);
		for (n = 0; n < 40 * p && tx_busy === 1'h1; n++) step(1);
		$display("test tx select %0d finished", sel);
	endtask : t_tx
	task automatic t_rx_async();
		@(posedge sys_clk);
		cfg_clk_select <= 2'h1;
		cfg_divisor <= 8'h00;
		step(4);
		pulse_read_clear();
		check("rts ready", cts_rts_out, 1'h0);
		u_peer.send(8'h3C, 32);
		step(2);
		check("rx word", rx_data, 8'h3C);
		check("rts after completion", cts_rts_out, 1'h1);
		check("rts driven", cts_rts_oe, 1'h1);
		fork
			u_peer.send(8'hC3, 32);
			begin
				step(258);
				check("overrun early", overrun_error, 1'h0);
				step(32);
				check("overrun late", overrun_error, 1'h1);
			end
		join
		step(2);
		check("rx kept", rx_data, 8'h3C);
		pulse_read_clear();
		check("rts after read", cts_rts_out, 1'h0);
		check("overrun cleared", overrun_error, 1'h0);
		$display("test async receive finished");
	endtask : t_rx_async
	task automatic t_split();
		int n;
		@(posedge sys_clk);
		cfg_handshake_split <= 1'h1;
		cfg_cts_enable <= 1'h1;
		u_peer.set_cts(1'h1);
		put(8'h5A);
		u_peer.send(8'h77, 32);
		step(2);
		check("split rts full", rts_n_sep, 1'h1);
		check("shared pin free", cts_rts_oe, 1'h0);
		check("cts holds line", txd, 1'h1);
		pulse_read_clear();
		check("split rts read", rts_n_sep, 1'h0);
		@(posedge sys_clk);
		u_peer.set_cts(1'h0);
		for (n = 0; n < 20 && txd === 1'h1; n++) step(1);
		check("cts release", txd, 1'h0);
		for (n = 0; n < 800 && tx_busy === 1'h1; n++) step(1);
		@(posedge sys_clk);
		cfg_handshake_split <= 1'h0;
		cfg_cts_enable <= 1'h0;
		$display("test split handshake finished");
	endtask : t_split
	task automatic t_sync_ovr();
		@(posedge sys_clk);
		cfg_sync_mode <= 1'h1;
		put(8'h11);
		put(8'h22);
		rises(8);
		step(4);
		check("sync word", rx_data, 8'h96);
		rises(6);
		step(2);
		check("sync overrun early", overrun_error, 1'h0);
		rises(1);
		step(4);
		check("sync overrun", overrun_error, 1'h1);
		rises(1);
		step(20);
		check("sync kept", rx_data, 8'h96);
		pulse_read_clear();
		@(posedge sys_clk);
		cfg_sync_mode <= 1'h0;
		$display("test sync overrun finished");
	endtask : t_sync_ovr
	task automatic t_twowire();
		@(posedge sys_clk);
		cfg_sync_mode <= 1'h1;
		cfg_twowire_mode <= 1'h1;
		gen_start <= 1'h1;
		@(posedge sys_clk);
		gen_start <= 1'h0;
		step(1);
		check("start sda", sda_oe, 1'h1);
		check("start scl", scl_oe, 1'h0);
		check("start busy", cond_busy, 1'h1);
		step(8);
		check("start held scl", scl_oe, 1'h1);
		check("start done", cond_busy, 1'h0);
		@(posedge sys_clk);
		gen_stop <= 1'h1;
		@(posedge sys_clk);
		gen_stop <= 1'h0;
		step(1);
		check("stop both low", sda_oe & scl_oe, 1'h1);
		step(12);
		check("stop released", sda_oe | scl_oe | cond_busy, 1'h0);
		@(posedge sys_clk);
		cfg_twowire_mode <= 1'h0;
		cfg_sync_mode <= 1'h0;
		$display("test two-wire conditions finished");
	endtask : t_twowire
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial
	begin
		step(3);
		check("reset txd", txd, 1'h1);
		check("reset sclk", sclk, 1'h1);
		check("reset full", rx_full, 1'h0);
		@(posedge sys_clk);
		reset_n <= 1'h1;
		step(4);
		t_tx(2'h0, 8'h02, 3);
		t_tx(2'h1, 8'h00, 2);
		t_tx(2'h2, 8'h01, 16);
		t_tx(2'h3, 8'h00, 32);
		t_rx_async();
		t_split();
		t_sync_ovr();
		t_twowire();
		wrap_up();
	end
	initial
	begin
		#300000;
		fails++;
		wrap_up();
	end
endmodule : tb_top

bind scu_channel scu_checker #(.DIV_WIDTH(DIV_WIDTH)) u_chk (.*);

`default_nettype wire
